// file: src/logger_pkg.sv
// Shared constants and types for the triggered data logger
package logger_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS    = 5;
    localparam int BASE_PERIOD_US   = 250;
    localparam int BASE_TICK_CYCLES = BASE_PERIOD_US * 1000 / CLK_PERIOD_NS;

    // ************************************************************
    // Buffer sizing
    // ************************************************************
    localparam int BUFFER_BYTES    = 2097152;
    localparam int TIMESTAMP_BYTES = 4;
    localparam int TIMESTAMP_W     = TIMESTAMP_BYTES * 8;
    localparam int MAX_SAMPLES     = BUFFER_BYTES / TIMESTAMP_BYTES;
    localparam int COUNT_W         = $clog2(MAX_SAMPLES + 1);
    localparam int FRACTION_SHIFT  = 2;

    // ************************************************************
    // Modes and states
    // ************************************************************
    typedef enum logic
    {
        OP_SINGLE   = 1'b0,
        OP_CIRCULAR = 1'b1
    } op_mode_t;

    typedef enum logic [1:0]
    {
        TRIG_NONE         = 2'h0,
        BEFORE_EVENT_MODE = 2'h1,
        AFTER_EVENT_MODE  = 2'h2,
        TRIG_COMBINED     = 2'h3
    } trigger_mode_t;

    typedef enum logic [1:0]
    {
        FRAC_QUARTER       = 2'h0,
        FRAC_HALF          = 2'h1,
        FRAC_THREE_QUARTER = 2'h2,
        FRAC_RESERVED      = 2'h3
    } post_fraction_t;

    typedef enum logic [1:0]
    {
        PERIOD_250US  = 2'h0,
        PERIOD_500US  = 2'h1,
        PERIOD_1000US = 2'h2,
        PERIOD_2000US = 2'h3
    } sample_period_t;

    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'h0,
        ST_ARMED = 3'h1,
        ST_LOG   = 3'h2,
        ST_POST  = 3'h3,
        ST_DONE  = 3'h4
    } logger_state_t;

endpackage : logger_pkg

// file: src/sample_tick_gen.sv
// Sample tick divider: one-cycle pulse at the selected sampling period
`timescale 1ns/1ps

module sample_tick_gen #(
    parameter int BASE_CYCLES = logger_pkg::BASE_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset,
    // Control
    input  wire logic                       restart,
    input  wire logger_pkg::sample_period_t period_sel,
    // Tick out
    output logic                            tick
);
    import logger_pkg::*;

    localparam int BW = $clog2(BASE_CYCLES);

    logic [BW-1:0] base_cnt_q;
    logic [2:0]    mult_q;
    logic          tick_q;
    logic          base_end;
    logic          mult_end;

    // Number of base periods minus one per sample
    function automatic logic [2:0] mult_limit(input sample_period_t sel);
        case (sel)
            PERIOD_250US:  mult_limit = 3'h0;
            PERIOD_500US:  mult_limit = 3'h1;
            PERIOD_1000US: mult_limit = 3'h3;
            PERIOD_2000US: mult_limit = 3'h7;
            default:       mult_limit = 3'h0;
        endcase
    endfunction : mult_limit

    // End of base period and of the multiple
    assign base_end = (base_cnt_q == BW'(BASE_CYCLES - 1));
    assign mult_end = (mult_q == mult_limit(period_sel));
    assign tick     = tick_q;

    // Base counter, multiplier, tick pulse
    always_ff @(posedge clk)
    begin
        if (reset || restart)
        begin
            base_cnt_q <= '0;
            mult_q     <= 3'h0;
            tick_q     <= 1'b0;
        end
        else
        begin
            base_cnt_q <= base_end ? '0 : base_cnt_q + BW'(1);
            if (base_end)
                mult_q <= mult_end ? 3'h0 : mult_q + 3'h1;
            tick_q <= base_end && mult_end;
        end
    end

endmodule : sample_tick_gen

// file: src/triggered_data_logger.sv
// Triggered sample capture engine with single and circular modes
`timescale 1ns/1ps

module triggered_data_logger #(
    parameter int TICK_CYCLES     = logger_pkg::BASE_TICK_CYCLES,
    parameter int SAMPLE_W        = 64,
    parameter int PAYLOAD_BYTES_W = 16
) (
    // Clock and reset
    input  wire logic                               clk,
    input  wire logic                               reset,
    // Configuration
    input  wire logger_pkg::op_mode_t               op_mode,
    input  wire logger_pkg::trigger_mode_t          trigger_mode,
    input  wire logger_pkg::post_fraction_t         post_trigger_fraction,
    input  wire logger_pkg::sample_period_t         sample_period,
    input  wire logic [logger_pkg::COUNT_W-1:0]     sample_count_setting,
    input  wire logic [PAYLOAD_BYTES_W-1:0]         sample_payload_bytes,
    // Host control
    input  wire logic                               logger_activate_command,
    input  wire logic                               trigger_input,
    // Sample source
    input  wire logic [SAMPLE_W-1:0]                sample_data,
    // Buffer write port
    output logic                                    buf_wr_en,
    output logic [logger_pkg::COUNT_W-1:0]          buf_wr_index,
    output logic [logger_pkg::TIMESTAMP_W+SAMPLE_W-1:0] buf_wr_data,
    // Status
    output logic                                    capture_ready_flag,
    output logic                                    logging_active,
    output logic                                    config_error,
    output logic [logger_pkg::COUNT_W-1:0]          trigger_index
);
    import logger_pkg::*;

    localparam int NB_W = COUNT_W + PAYLOAD_BYTES_W + 1;
    localparam int PW   = COUNT_W + 3;
    localparam int DW   = TIMESTAMP_W + SAMPLE_W;

    // ************************************************************
    // Declarations
    // ************************************************************
    logger_state_t      st_q;
    logger_state_t      st_d;
    logic               act_q;
    logic               trig_q;
    logic               ready_q;
    logic               ready_d;
    logic               err_q;
    logic               err_d;
    logic               active_q;
    op_mode_t           mode_q;
    trigger_mode_t      tmode_q;
    logic [COUNT_W-1:0] limit_q;
    logic [COUNT_W-1:0] post_target_q;
    logic [COUNT_W-1:0] wr_idx_q;
    logic [COUNT_W-1:0] stored_q;
    logic [COUNT_W-1:0] post_cnt_q;
    logic [COUNT_W-1:0] trig_idx_q;
    logic [TIMESTAMP_W-1:0] ts_q;
    logic               wr_en_q;
    logic [COUNT_W-1:0] wr_out_q;
    logic [DW-1:0]      wr_data_q;

    logic               en_rise;
    logic               tr_rise;
    logic               tr_fall;
    logic               tick;
    logic               logging;
    logic               write_now;
    logic               wr_last;
    logic               post_last;
    logic               start;
    logic               pre_style;
    logic               cfg_bad;
    logic [NB_W-1:0]    need_bytes;
    logic [NB_W-1:0]    set_bytes;
    logic [2:0]         frac_num;
    logic [PW-1:0]      post_prod;

    // ************************************************************
    // Edge detection and configuration checks
    // ************************************************************
    assign en_rise   = logger_activate_command && !act_q;
    assign tr_rise   = trigger_input && !trig_q;
    assign tr_fall   = !trigger_input && trig_q;
    assign pre_style = (trigger_mode == BEFORE_EVENT_MODE) || (trigger_mode == TRIG_COMBINED);

    // Bytes needed for the requested count, timestamp included
    assign set_bytes  = NB_W'(sample_payload_bytes) + NB_W'(TIMESTAMP_BYTES);
    assign need_bytes = NB_W'(sample_count_setting) * set_bytes;

    // Refused set-ups: bad mode pairing, bad fraction, empty or oversize
    assign cfg_bad = ((op_mode == OP_SINGLE) && pre_style)
                   || (pre_style && (post_trigger_fraction == FRAC_RESERVED))
                   || (sample_count_setting == '0)
                   || (need_bytes > NB_W'(BUFFER_BYTES));
    assign start   = en_rise && !cfg_bad;

    // Post-trigger sample target from fraction
    assign frac_num  = {1'b0, post_trigger_fraction} + 3'h1;
    assign post_prod = PW'(sample_count_setting) * PW'(frac_num);

    // Write control
    assign logging   = (st_q == ST_LOG) || (st_q == ST_POST);
    assign write_now = tick && logging && logger_activate_command;
    assign wr_last   = (wr_idx_q == limit_q - COUNT_W'(1));
    assign post_last = (post_cnt_q + COUNT_W'(1) >= post_target_q);

    // ************************************************************
    // Sample tick divider
    // ************************************************************
    sample_tick_gen #(
        .BASE_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk        (clk),
        .reset      (reset),
        .restart    (start),
        .period_sel (sample_period),
        .tick       (tick)
    );

    // ************************************************************
    // Control state machine
    // ************************************************************
    always_comb
    begin
        st_d    = st_q;
        ready_d = ready_q;
        err_d   = err_q;
        case (st_q)
            ST_IDLE, ST_DONE:
            begin
                if (en_rise && cfg_bad)
                    err_d = 1'b1;
                else if (start)
                begin
                    err_d   = 1'b0;
                    ready_d = 1'b0;
                    // Circular after-event waits for the trigger
                    if (op_mode == OP_CIRCULAR && trigger_mode == AFTER_EVENT_MODE)
                        st_d = ST_ARMED;
                    else
                        st_d = ST_LOG;
                end
            end
            ST_ARMED:
            begin
                if (!logger_activate_command)
                    st_d = ST_IDLE;
                else if (tr_rise)
                    st_d = ST_LOG;
            end
            ST_LOG:
            begin
                if (!logger_activate_command)
                begin
                    st_d    = ST_IDLE;
                    ready_d = (stored_q != '0);
                end
                else if (tmode_q == AFTER_EVENT_MODE && tr_fall)
                begin
                    st_d = ST_IDLE;
                    if (mode_q == OP_SINGLE)
                        ready_d = 1'b1;
                    else
                        ready_d = (stored_q != '0) || write_now;
                end
                else if ((tmode_q == BEFORE_EVENT_MODE || tmode_q == TRIG_COMBINED)
                         && tr_rise)
                    st_d = ST_POST;
                else if (write_now && wr_last && mode_q == OP_SINGLE)
                begin
                    st_d    = ST_DONE;
                    ready_d = 1'b1;
                end
                else if (write_now && tmode_q == TRIG_NONE
                         && stored_q == limit_q - COUNT_W'(1))
                    ready_d = 1'b1;
            end
            ST_POST:
            begin
                if (!logger_activate_command)
                begin
                    st_d    = ST_IDLE;
                    ready_d = (stored_q != '0);
                end
                else if (write_now && post_last
                         && (tmode_q == BEFORE_EVENT_MODE || trigger_input))
                begin
                    st_d    = ST_DONE;
                    ready_d = 1'b1;
                end
            end
            default:
                st_d = ST_IDLE;
        endcase
    end

    // State, flags and edge history
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_q     <= ST_IDLE;
            act_q    <= 1'b0;
            trig_q   <= 1'b0;
            ready_q  <= 1'b0;
            err_q    <= 1'b0;
            active_q <= 1'b0;
        end
        else
        begin
            st_q     <= st_d;
            act_q    <= logger_activate_command;
            trig_q   <= trigger_input;
            ready_q  <= ready_d;
            err_q    <= err_d;
            active_q <= (st_d == ST_LOG) || (st_d == ST_POST);
        end
    end

    // ************************************************************
    // Datapath: latched set-up, indices, timestamp
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            mode_q        <= OP_SINGLE;
            tmode_q       <= TRIG_NONE;
            limit_q       <= '0;
            post_target_q <= '0;
            wr_idx_q      <= '0;
            stored_q      <= '0;
            post_cnt_q    <= '0;
            trig_idx_q    <= '0;
            ts_q          <= '0;
        end
        else if (start && (st_q == ST_IDLE || st_q == ST_DONE))
        begin
            mode_q        <= op_mode;
            tmode_q       <= trigger_mode;
            limit_q       <= sample_count_setting;
            post_target_q <= post_prod[COUNT_W+1:FRACTION_SHIFT];
            wr_idx_q      <= '0;
            stored_q      <= '0;
            post_cnt_q    <= '0;
            trig_idx_q    <= '0;
            ts_q          <= '0;
        end
        else
        begin
            // Timestamp counts sample intervals since activation
            if (tick)
                ts_q <= ts_q + TIMESTAMP_W'(1);
            // Wrap to buffer start after the set count
            if (write_now)
            begin
                wr_idx_q <= wr_last ? '0 : wr_idx_q + COUNT_W'(1);
                if (stored_q != limit_q)
                    stored_q <= stored_q + COUNT_W'(1);
                if (st_q == ST_POST)
                    post_cnt_q <= post_cnt_q + COUNT_W'(1);
            end
            // Position of the first post-trigger sample
            if (st_q == ST_LOG && st_d == ST_POST)
                trig_idx_q <= write_now ? (wr_last ? '0 : wr_idx_q + COUNT_W'(1))
                                        : wr_idx_q;
        end
    end

    // Buffer write register: sample with its timestamp
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wr_en_q   <= 1'b0;
            wr_out_q  <= '0;
            wr_data_q <= '0;
        end
        else
        begin
            wr_en_q <= write_now;
            if (write_now)
            begin
                wr_out_q  <= wr_idx_q;
                wr_data_q <= {ts_q, sample_data};
            end
        end
    end

    // Outputs straight from flops
    assign buf_wr_en          = wr_en_q;
    assign buf_wr_index       = wr_out_q;
    assign buf_wr_data        = wr_data_q;
    assign capture_ready_flag = ready_q;
    assign logging_active     = active_q;
    assign config_error       = err_q;
    assign trigger_index      = trig_idx_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence seq_single_pre_req;
        en_rise && (st_q == ST_IDLE || st_q == ST_DONE) && op_mode == OP_SINGLE
            && trigger_mode == BEFORE_EVENT_MODE;
    endsequence

    sequence seq_post_done;
        st_q == ST_POST && write_now && post_last && tmode_q == BEFORE_EVENT_MODE
            && logger_activate_command;
    endsequence

    chk_single_mode_refuse: assert property (
        seq_single_pre_req |=> config_error && !logging_active)
        else $error("single mode accepted a before-event trigger");

    chk_single_fill_stop: assert property (
        st_q == ST_LOG && mode_q == OP_SINGLE && write_now && wr_last
            && !tr_fall && !tr_rise
        |=> capture_ready_flag && !logging_active ##1 !buf_wr_en[*2])
        else $error("single mode did not stop after the set count");

    chk_deactivate_stop: assert property (
        logging && !logger_activate_command |=> !logging_active)
        else $error("logging continued after deactivation");

    chk_circ_wrap: assert property (
        write_now && mode_q == OP_CIRCULAR && wr_last && logger_activate_command
        |=> wr_idx_q == '0)
        else $error("circular write index did not wrap");

    chk_circ_accept: assert property (
        en_rise && (st_q == ST_IDLE) && op_mode == OP_CIRCULAR && !cfg_bad
        |=> !config_error && (logging_active || st_q == ST_ARMED))
        else $error("circular mode refused a trigger mode");

    chk_circ_first_fill: assert property (
        st_q == ST_LOG && tmode_q == TRIG_NONE && mode_q == OP_CIRCULAR && write_now
            && stored_q == limit_q - COUNT_W'(1)
        |=> capture_ready_flag)
        else $error("ready not raised on first buffer fill");

    chk_stop_ready: assert property (
        logging && !logger_activate_command
        |=> capture_ready_flag == ($past(stored_q) != '0))
        else $error("ready flag wrong after deactivation");

    chk_post_finish: assert property (
        seq_post_done |=> st_q == ST_DONE && capture_ready_flag && !logging_active)
        else $error("before-event capture did not finish");

    chk_circ_trig_start: assert property (
        st_q == ST_ARMED && logger_activate_command && tr_rise |=> logging_active)
        else $error("after-event logging did not start on trigger");

    chk_post_count: assert property (
        st_q == ST_DONE && $past(st_q) == ST_POST |-> post_cnt_q >= post_target_q)
        else $error("post-trigger samples short of target");

    chk_first_write: assert property (
        st_q == ST_LOG && stored_q == '0 && write_now |=> buf_wr_en && buf_wr_index == '0)
        else $error("first sample not written at index zero");

endmodule : triggered_data_logger

// file: testbench/host_model.sv
// Host controller model driving activate and trigger levels
`timescale 1ns/1ps
module host_model (
    // Clock
    input  wire logic clk,
    // Host control levels
    output logic      act,
    output logic      trig
);
    // Both levels start low
    initial
    begin
        act  = 1'b0;
        trig = 1'b0;
    end

    // Activate level, changed on the edge
    task automatic set_act(input logic v);
        @(posedge clk);
        act <= v;
    endtask : set_act

    // Trigger level, changed on the edge
    task automatic set_trig(input logic v);
        @(posedge clk);
        trig <= v;
    endtask : set_trig
endmodule : host_model

// file: testbench/tb_top.sv
// Self-checking testbench for the triggered data logger
`timescale 1ns/1ps
module tb_top;
    import logger_pkg::*;
    localparam int TC = 8;
    logic               clk;
    logic               reset;
    op_mode_t           om;
    trigger_mode_t      tm;
    logic [COUNT_W-1:0] cnt;
    logic               act;
    logic               trig;
    logic               wr_en;
    logic [COUNT_W-1:0] wr_idx;
    logic [95:0]        wr_data;
    logic               ready;
    logic               active;
    logic               cerr;
    post_fraction_t     frac;
    sample_period_t     per;
    logic [15:0]        pay;
    logic [63:0]        sdata;
    logic [COUNT_W-1:0] tidx;
    int                 since;
    int                 nw;
    int                 wrap;
    int                 num_errors;
    int                 compares;
    int                 cyc;

    // Design under test, whole set-up driven by the bench
    triggered_data_logger #(.TICK_CYCLES(TC)) u_dut (
        .clk(clk), .reset(reset), .op_mode(om), .trigger_mode(tm),
        .post_trigger_fraction(frac), .sample_period(per),
        .sample_count_setting(cnt), .sample_payload_bytes(pay),
        .logger_activate_command(act), .trigger_input(trig),
        .sample_data(sdata), .buf_wr_en(wr_en),
        .buf_wr_index(wr_idx), .buf_wr_data(wr_data), .capture_ready_flag(ready),
        .logging_active(active), .config_error(cerr), .trigger_index(tidx));
    host_model u_host (.clk(clk), .act(act), .trig(trig));

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask : check

    task automatic wrap_up();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    // Each buffer write: slot, timestamp, payload and spacing
    always @(posedge clk)
    begin
        since++;
        if (wr_en === 1'b1)
        begin
            check("index", nw % wrap, wr_idx);
            check("stamp", nw, wr_data[95:64]);
            check("sample", sdata[31:0], wr_data[31:0]);
            check("sample_hi", sdata[63:32], wr_data[63:32]);
            if (nw > 0)
                check("gap", TC << per, since);
            since = 0;
            nw = nw + 1;
        end
    end

    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : settle

    task automatic go(input op_mode_t o, input trigger_mode_t t, input int c);
        @(posedge clk);
        om   <= o;
        tm   <= t;
        cnt  <= COUNT_W'(c);
        wrap = (c == 0) ? 1 : c;
        nw   = 0;
        u_host.set_act(1'b1);
    endtask : go

    task automatic stop();
        u_host.set_act(1'b0);
        settle(2);
    endtask : stop

    task automatic wait_w(input int n);
        for (int i = 0; i < 400 && nw < n; i++)
            @(posedge clk);
        #1;
        check("writes", n, nw);
    endtask : wait_w

    task automatic try_cfg(input op_mode_t o, input trigger_mode_t t, input int c, input logic e);
        go(o, t, c);
        settle(3);
        check("cfg_err", e, cerr);
        check("active", !e, active);
        stop();
    endtask : try_cfg

    // Test sequence
    initial
    begin
        reset = 1'b1;
        om = OP_SINGLE;
        tm = TRIG_NONE;
        cnt = '0;
        frac = FRAC_QUARTER;
        per = PERIOD_250US;
        pay = 16'h0010;
        sdata = 64'h0123_4567_89AB_CDEF;
        since = 0;
        num_errors = 0;
        compares = 0;
        cyc = 0;
        nw = 0;
        wrap = 1;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        go(OP_SINGLE, TRIG_NONE, 2);
        wait_w(2);
        settle(30);
        check("ready", 1, ready);
        check("active", 0, active);
        check("writes", 2, nw);
        stop();
        go(OP_SINGLE, TRIG_NONE, 5);
        wait_w(1);
        stop();
        check("active", 0, active);
        check("ready", 1, ready);
        settle(30);
        check("writes", 1, nw);
        try_cfg(OP_SINGLE, BEFORE_EVENT_MODE, 2, 1'b1);
        try_cfg(OP_SINGLE, TRIG_COMBINED, 2, 1'b1);
        try_cfg(OP_CIRCULAR, TRIG_NONE, 104858, 1'b1);
        try_cfg(OP_CIRCULAR, TRIG_NONE, 104857, 1'b0);
        try_cfg(OP_CIRCULAR, BEFORE_EVENT_MODE, 4, 1'b0);
        try_cfg(OP_CIRCULAR, TRIG_COMBINED, 4, 1'b0);
        @(posedge clk);
        frac <= FRAC_RESERVED;
        try_cfg(OP_CIRCULAR, BEFORE_EVENT_MODE, 4, 1'b1);
        @(posedge clk);
        frac <= FRAC_QUARTER;
        pay  <= 16'h00FC;
        try_cfg(OP_CIRCULAR, TRIG_NONE, 8192, 1'b0);
        try_cfg(OP_CIRCULAR, TRIG_NONE, 8193, 1'b1);
        @(posedge clk);
        pay <= 16'h0010;
        u_host.set_trig(1'b1);
        go(OP_SINGLE, AFTER_EVENT_MODE, 8);
        wait_w(2);
        u_host.set_trig(1'b0);
        settle(2);
        check("active", 0, active);
        check("ready", 1, ready);
        stop();
        @(posedge clk);
        per <= PERIOD_2000US;
        go(OP_CIRCULAR, TRIG_NONE, 2);
        wait_w(3);
        check("ready", 1, ready);
        stop();
        check("active", 0, active);
        @(posedge clk);
        per <= PERIOD_250US;
        go(OP_CIRCULAR, AFTER_EVENT_MODE, 4);
        settle(3);
        check("armed", 0, active);
        u_host.set_trig(1'b1);
        wait_w(2);
        u_host.set_trig(1'b0);
        settle(2);
        check("active", 0, active);
        check("ready", 1, ready);
        stop();
        // Pre and combined: one pre sample, then a quarter or half of four after trigger
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk);
            frac <= (k == 2) ? FRAC_HALF : FRAC_QUARTER;
            go(OP_CIRCULAR, (k == 1) ? TRIG_COMBINED : BEFORE_EVENT_MODE, 4);
            wait_w(1);
            u_host.set_trig(1'b1);
            wait_w((k == 2) ? 3 : 2);
            settle(40);
            check("active", 0, active);
            check("ready", 1, ready);
            check("writes", (k == 2) ? 3 : 2, nw);
            check("trig_index", 1, tidx);
            u_host.set_trig(1'b0);
            stop();
        end
        wrap_up();
    end
endmodule : tb_top
